// ### include/scfg_defines.svh
// register offsets, field positions, reset values and timing figures
// assumes an 8-bit register space addressed by the primary interface
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH

`define SCFG_ADDR_FEAT       8'h5E
`define SCFG_ADDR_FAULT      8'h5F
`define SCFG_ADDR_NVMC       8'h6A
`define SCFG_ADDR_IFSET      8'h6B
`define SCFG_ADDR_SELFTEST   8'h6D
`define SCFG_ADDR_PERSIST    8'h70
`define SCFG_ADDR_OFF_X      8'h71
`define SCFG_ADDR_OFF_Y      8'h72
`define SCFG_ADDR_OFF_Z      8'h73
`define SCFG_ADDR_CMD        8'h7E

`define SCFG_RST_BYTE        8'h00
`define SCFG_READ_ZERO       8'h00
`define SCFG_CMD_NVM_PROG    8'hA0

`define SCFG_MASK_FAULT      8'h06
`define SCFG_MASK_NVMC       8'h02
`define SCFG_MASK_IFSET      8'h11
`define SCFG_MASK_SELFTEST   8'h0D
`define SCFG_MASK_PERSIST    8'h0F

`define SCFG_BIT_ERR_LONG    1
`define SCFG_BIT_ERR_FATAL   2
`define SCFG_BIT_NVM_PROG_EN 1
`define SCFG_BIT_THREE_WIRE  0
`define SCFG_BIT_AUX_MAG     4
`define SCFG_BIT_ST_EN       0
`define SCFG_BIT_ST_SIGN     2
`define SCFG_BIT_ST_AMP      3
`define SCFG_BIT_SPI_EN      0
`define SCFG_BIT_WDT_SEL     1
`define SCFG_BIT_WDT_EN      2
`define SCFG_BIT_OFF_EN      3

`define SCFG_AXES            3
`define SCFG_ACC_MAX         17'sh07FFF
`define SCFG_ACC_MIN         17'sh18000

`define SCFG_CLK_PERIOD_NS   10
`define SCFG_WDT_SHORT_NS    1250000
`define SCFG_WDT_LONG_NS     40000000
`define SCFG_WDT_CNT_W       22

`endif

// ### include/scfg_pkg.sv
// types shared by the register bank and its watchdog
// assumes scfg_defines.svh for the constants
package scfg_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } scfg_reg_req_t;

   typedef struct packed {
      logic [7:0] persist;
      logic [7:0] off_x;
      logic [7:0] off_y;
      logic [7:0] off_z;
   } scfg_nvm_image_t;

   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } scfg_acc_t;

   typedef enum logic [2:0] {
      SCFG_WDT_IDLE    = 3'h1,
      SCFG_WDT_COUNT   = 3'h2,
      SCFG_WDT_TRIPPED = 3'h4
   } scfg_wdt_state_t;

endpackage

// ### rtl/scfg_sda_watchdog.sv
// watchdog on the SDA line of the primary interface in I2C mode
// assumes sda_pin is asynchronous; other inputs are on clk
`timescale 1ns/1ps
`include "scfg_defines.svh"

module scfg_sda_watchdog #(
   parameter int unsigned SHORT_CYC = 125000,
   parameter int unsigned LONG_CYC  = 4000000
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic sda_pin,
   input  wire logic i2c_mode,
   input  wire logic enable,
   input  wire logic long_sel,
   output logic      expire
);
   import scfg_pkg::*;

   localparam logic [`SCFG_WDT_CNT_W-1:0] SHORT_LIM =
      `SCFG_WDT_CNT_W'(SHORT_CYC - 1);
   localparam logic [`SCFG_WDT_CNT_W-1:0] LONG_LIM =
      `SCFG_WDT_CNT_W'(LONG_CYC - 1);

   logic                       sda_meta_q;
   logic                       sda_q;
   logic [`SCFG_WDT_CNT_W-1:0] cnt_q;
   logic [`SCFG_WDT_CNT_W-1:0] limit;
   logic                       armed;
   scfg_wdt_state_t            state_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sda_meta_q <= 1'b1;
         sda_q      <= 1'b1;
      end
      else
      begin
         sda_meta_q <= sda_pin;
         sda_q      <= sda_meta_q;
      end
   end

   assign limit = long_sel ? LONG_LIM : SHORT_LIM;
   assign armed = enable && i2c_mode;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q <= SCFG_WDT_IDLE;
         cnt_q   <= '0;
         expire  <= 1'b0;
      end
      else
      begin
         expire <= 1'b0;
         case (state_q)
            SCFG_WDT_IDLE:
            begin
               cnt_q <= '0;
               if (armed && !sda_q)
                  state_q <= SCFG_WDT_COUNT;
            end
            SCFG_WDT_COUNT:
            begin
               if (!armed || sda_q)
               begin
                  state_q <= SCFG_WDT_IDLE;
               end
               else if (cnt_q >= limit)
               begin
                  expire  <= 1'b1;
                  state_q <= SCFG_WDT_TRIPPED;
               end
               else
               begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            SCFG_WDT_TRIPPED:
            begin
               // one release per stuck episode; wait for sda to rise
               cnt_q <= '0;
               if (!armed || sda_q)
                  state_q <= SCFG_WDT_IDLE;
            end
            default:
            begin
               state_q <= SCFG_WDT_IDLE;
               cnt_q   <= '0;
            end
         endcase
      end
   end

endmodule

// ### rtl/scfg_regs.sv
// configuration and status register bank of the accelerometer core
// assumes a register port driven by the serial engines on REF_CLK,
// and an nvm controller, feature engine and data path on REF_CLK
`timescale 1ns/1ps
`include "scfg_defines.svh"

module scfg_regs #(
   parameter int unsigned WDT_SHORT_CYC =
      `SCFG_WDT_SHORT_NS / `SCFG_CLK_PERIOD_NS,
   parameter int unsigned WDT_LONG_CYC =
      `SCFG_WDT_LONG_NS / `SCFG_CLK_PERIOD_NS
) (
   input  wire logic                  REF_CLK,
   input  wire logic                  RST,
   input  wire scfg_pkg::scfg_reg_req_t REG_REQ,
   output logic [7:0]                 REG_RDATA,
   output logic                       REG_RVALID,
   output logic [7:0]                 FEAT_DATA,
   output logic                       FEAT_WR_PULSE,
   output logic                       FEAT_RD_PULSE,
   input  wire logic                  ERR_LONG_PROC,
   input  wire logic                  ERR_FATAL,
   output logic                       PROC_HALT,
   output logic                       NVM_PROG_ENABLE,
   output logic                       NVM_PROG_STB,
   output scfg_pkg::scfg_nvm_image_t  NVM_PROG_IMAGE,
   input  wire logic                  NVM_LOAD,
   input  wire scfg_pkg::scfg_nvm_image_t NVM_LOAD_IMAGE,
   output logic                       THREE_WIRE_SELECT,
   output logic                       AUX_MAG_ENABLE,
   output logic                       SELFTEST_ENABLE,
   output logic                       SELFTEST_POSITIVE,
   output logic                       SELFTEST_HIGH_AMP,
   output logic                       SPI_SELECT,
   input  wire logic                  I2C_MODE,
   input  wire logic                  SDA_IN,
   output logic                       SDA_RELEASE,
   input  wire logic                  ACC_IN_VALID,
   input  wire scfg_pkg::scfg_acc_t   ACC_IN,
   output logic                       ACC_OUT_VALID,
   output scfg_pkg::scfg_acc_t        ACC_OUT
);
   import scfg_pkg::*;

   logic [7:0] feat_q;
   logic [7:0] fault_q;
   logic [7:0] nvmc_q;
   logic [7:0] ifset_q;
   logic [7:0] selftest_q;
   logic [7:0] persist_q;
   logic [7:0] off_q [`SCFG_AXES];
   logic [7:0] rdata_d;
   logic       wr_feat;
   logic       wr_nvmc;
   logic       wr_ifset;
   logic       wr_selftest;
   logic       wr_persist;
   logic       wr_cmd;
   logic       halted;
   logic [15:0] acc_in_axis  [`SCFG_AXES];
   logic [15:0] acc_out_axis [`SCFG_AXES];

   // write strobe for one register address
   function automatic logic hit_wr(input scfg_reg_req_t req,
                                   input logic [7:0]    addr);
      hit_wr = req.wr && (req.addr == addr);
   endfunction

   // signed 16-bit plus signed byte, clamped to the 16-bit range
   function automatic logic [15:0] sat_add(input logic [15:0] a,
                                           input logic [7:0]  b);
      logic signed [16:0] sum;
      sum = $signed({a[15], a}) + $signed({{9{b[7]}}, b});
      if (sum > `SCFG_ACC_MAX)
         sat_add = 16'h7FFF;
      else if (sum < `SCFG_ACC_MIN)
         sat_add = 16'h8000;
      else
         sat_add = sum[15:0];
   endfunction

   assign wr_feat     = hit_wr(REG_REQ, `SCFG_ADDR_FEAT);
   assign wr_nvmc     = hit_wr(REG_REQ, `SCFG_ADDR_NVMC);
   assign wr_ifset    = hit_wr(REG_REQ, `SCFG_ADDR_IFSET);
   assign wr_selftest = hit_wr(REG_REQ, `SCFG_ADDR_SELFTEST);
   assign wr_persist  = hit_wr(REG_REQ, `SCFG_ADDR_PERSIST);
   assign wr_cmd      = hit_wr(REG_REQ, `SCFG_ADDR_CMD);
   assign halted      = fault_q[`SCFG_BIT_ERR_LONG]
                     || fault_q[`SCFG_BIT_ERR_FATAL];

   // feature engine port
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         feat_q        <= `SCFG_RST_BYTE;
         FEAT_WR_PULSE <= 1'b0;
         FEAT_RD_PULSE <= 1'b0;
      end
      else
      begin
         if (wr_feat)
            feat_q <= REG_REQ.wdata;
         FEAT_WR_PULSE <= wr_feat;
         FEAT_RD_PULSE <= REG_REQ.rd
                       && (REG_REQ.addr == `SCFG_ADDR_FEAT);
      end
   end

   // fault flags: set by the engine, never by the host
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         fault_q   <= `SCFG_RST_BYTE;
         PROC_HALT <= 1'b0;
      end
      else
      begin
         if (ERR_LONG_PROC)
            fault_q[`SCFG_BIT_ERR_LONG] <= 1'b1;
         if (ERR_FATAL)
            fault_q[`SCFG_BIT_ERR_FATAL] <= 1'b1;
         PROC_HALT <= halted || ERR_LONG_PROC || ERR_FATAL;
      end
   end

   // plain control registers, reserved bits masked on write
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         nvmc_q     <= `SCFG_RST_BYTE;
         ifset_q    <= `SCFG_RST_BYTE;
         selftest_q <= `SCFG_RST_BYTE;
      end
      else
      begin
         if (wr_nvmc)
            nvmc_q <= REG_REQ.wdata & `SCFG_MASK_NVMC;
         if (wr_ifset)
            ifset_q <= REG_REQ.wdata & `SCFG_MASK_IFSET;
         if (wr_selftest)
            selftest_q <= REG_REQ.wdata & `SCFG_MASK_SELFTEST;
      end
   end

   // nvm-backed bits and offsets; a host write wins over a load
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         persist_q <= `SCFG_RST_BYTE;
      else if (wr_persist)
         persist_q <= REG_REQ.wdata & `SCFG_MASK_PERSIST;
      else if (NVM_LOAD)
         persist_q <= NVM_LOAD_IMAGE.persist & `SCFG_MASK_PERSIST;
   end

   generate
      for (genvar i = 0; i < `SCFG_AXES; i++)
      begin : g_off
         always_ff @(posedge REF_CLK)
         begin
            if (RST)
               off_q[i] <= `SCFG_RST_BYTE;
            else if (hit_wr(REG_REQ, 8'(`SCFG_ADDR_OFF_X + i)))
               off_q[i] <= REG_REQ.wdata;
            else if (NVM_LOAD)
               off_q[i] <= NVM_LOAD_IMAGE[8*(2-i) +: 8];
         end
      end
   endgenerate

   // program command: refused while programming is disabled
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         NVM_PROG_STB   <= 1'b0;
         NVM_PROG_IMAGE <= '0;
      end
      else
      begin
         NVM_PROG_STB <= 1'b0;
         if (wr_cmd && (REG_REQ.wdata == `SCFG_CMD_NVM_PROG)
             && nvmc_q[`SCFG_BIT_NVM_PROG_EN])
         begin
            NVM_PROG_STB           <= 1'b1;
            NVM_PROG_IMAGE.persist <= persist_q;
            NVM_PROG_IMAGE.off_x   <= off_q[0];
            NVM_PROG_IMAGE.off_y   <= off_q[1];
            NVM_PROG_IMAGE.off_z   <= off_q[2];
         end
      end
   end

   // read mux; unmapped, reserved and command read as zero
   always_comb
   begin
      rdata_d = `SCFG_READ_ZERO;
      case (REG_REQ.addr)
         `SCFG_ADDR_FEAT:     rdata_d = feat_q;
         `SCFG_ADDR_FAULT:    rdata_d = fault_q & `SCFG_MASK_FAULT;
         `SCFG_ADDR_NVMC:     rdata_d = nvmc_q;
         `SCFG_ADDR_IFSET:    rdata_d = ifset_q;
         `SCFG_ADDR_SELFTEST: rdata_d = selftest_q;
         `SCFG_ADDR_PERSIST:  rdata_d = persist_q;
         `SCFG_ADDR_OFF_X:    rdata_d = off_q[0];
         `SCFG_ADDR_OFF_Y:    rdata_d = off_q[1];
         `SCFG_ADDR_OFF_Z:    rdata_d = off_q[2];
         default:             rdata_d = `SCFG_READ_ZERO;
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         REG_RDATA  <= `SCFG_READ_ZERO;
         REG_RVALID <= 1'b0;
      end
      else
      begin
         REG_RVALID <= REG_REQ.rd;
         if (REG_REQ.rd)
            REG_RDATA <= rdata_d;
      end
   end

   // registered control outputs
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         FEAT_DATA         <= `SCFG_RST_BYTE;
         NVM_PROG_ENABLE   <= 1'b0;
         THREE_WIRE_SELECT <= 1'b0;
         AUX_MAG_ENABLE    <= 1'b0;
         SELFTEST_ENABLE   <= 1'b0;
         SELFTEST_POSITIVE <= 1'b0;
         SELFTEST_HIGH_AMP <= 1'b0;
         SPI_SELECT        <= 1'b0;
      end
      else
      begin
         FEAT_DATA         <= feat_q;
         NVM_PROG_ENABLE   <= nvmc_q[`SCFG_BIT_NVM_PROG_EN];
         THREE_WIRE_SELECT <= ifset_q[`SCFG_BIT_THREE_WIRE];
         AUX_MAG_ENABLE    <= ifset_q[`SCFG_BIT_AUX_MAG];
         SELFTEST_ENABLE   <= selftest_q[`SCFG_BIT_ST_EN];
         SELFTEST_POSITIVE <= selftest_q[`SCFG_BIT_ST_SIGN];
         SELFTEST_HIGH_AMP <= selftest_q[`SCFG_BIT_ST_AMP];
         SPI_SELECT        <= persist_q[`SCFG_BIT_SPI_EN];
      end
   end

   scfg_sda_watchdog #(
      .SHORT_CYC (WDT_SHORT_CYC),
      .LONG_CYC  (WDT_LONG_CYC)
   ) u_wdt (
      .clk      (REF_CLK),
      .rst      (RST),
      .sda_pin  (SDA_IN),
      .i2c_mode (I2C_MODE),
      .enable   (persist_q[`SCFG_BIT_WDT_EN]),
      .long_sel (persist_q[`SCFG_BIT_WDT_SEL]),
      .expire   (SDA_RELEASE)
   );

   // offset compensation; output valid is held off while processing halts, data still updates
   assign acc_in_axis[0] = ACC_IN.x;
   assign acc_in_axis[1] = ACC_IN.y;
   assign acc_in_axis[2] = ACC_IN.z;

   generate
      for (genvar a = 0; a < `SCFG_AXES; a++)
      begin : g_acc
         always_ff @(posedge REF_CLK)
         begin
            if (RST)
               acc_out_axis[a] <= '0;
            else if (ACC_IN_VALID)
               acc_out_axis[a] <= persist_q[`SCFG_BIT_OFF_EN]
                               ? sat_add(acc_in_axis[a], off_q[a])
                               : acc_in_axis[a];
         end
      end
   endgenerate

   assign ACC_OUT.x = acc_out_axis[0];
   assign ACC_OUT.y = acc_out_axis[1];
   assign ACC_OUT.z = acc_out_axis[2];

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         ACC_OUT_VALID <= 1'b0;
      else
         ACC_OUT_VALID <= ACC_IN_VALID && !halted;
   end

endmodule

// ### bench/scfg_regs_checker.sv
// concurrent checks on the ports of the register bank
// assumes binding into scfg_regs, synchronous active-high RST
`timescale 1ns/1ps
module scfg_regs_checker (
   input wire logic                    REF_CLK,
   input wire logic                    RST,
   input wire scfg_pkg::scfg_reg_req_t REG_REQ,
   input wire logic [7:0]              REG_RDATA,
   input wire logic                    REG_RVALID,
   input wire logic                    FEAT_WR_PULSE,
   input wire logic                    ERR_LONG_PROC,
   input wire logic                    ERR_FATAL,
   input wire logic                    PROC_HALT,
   input wire logic                    NVM_PROG_STB,
   input wire logic                    THREE_WIRE_SELECT,
   input wire logic                    AUX_MAG_ENABLE,
   input wire logic                    SELFTEST_ENABLE,
   input wire logic                    SELFTEST_POSITIVE,
   input wire logic                    SELFTEST_HIGH_AMP,
   input wire logic                    SPI_SELECT,
   input wire logic                    SDA_RELEASE,
   input wire logic                    ACC_IN_VALID,
   input wire logic                    ACC_OUT_VALID
);
   import scfg_pkg::*;
   scfg_reg_req_t req_q;

   // request of the previous cycle, for checks one cycle on
   always_ff @(posedge REF_CLK)
   begin
      req_q <= REG_REQ;
   end

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   property p_rd_answer;
      REG_REQ.rd |=> REG_RVALID;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read not answered next cycle");
   property p_feat_wr;
      REG_REQ.wr && REG_REQ.addr == 8'h5E |=> FEAT_WR_PULSE;
   endproperty
   a_feat_wr: assert property (p_feat_wr)
      else $error("feature write pulse missing");
   property p_halt_set;
      ERR_LONG_PROC || ERR_FATAL |=> PROC_HALT;
   endproperty
   a_halt_set: assert property (p_halt_set)
      else $error("halt not raised on fault");
   property p_halt_hold;
      PROC_HALT |=> PROC_HALT [*3];
   endproperty
   a_halt_hold: assert property (p_halt_hold)
      else $error("halt dropped without reset");
   property p_halt_block;
      PROC_HALT && ACC_IN_VALID |=> !ACC_OUT_VALID;
   endproperty
   a_halt_block: assert property (p_halt_block)
      else $error("data passed while halted");
   property p_prog_cause;
      NVM_PROG_STB |-> req_q.wr && req_q.addr == 8'h7E
                       && req_q.wdata == 8'hA0;
   endproperty
   a_prog_cause: assert property (p_prog_cause)
      else $error("program strobe without command");
   // control pins follow their register one cycle later, two after a write
   property p_ifset;
      REG_REQ.wr && REG_REQ.addr == 8'h6B |-> ##2
         THREE_WIRE_SELECT == $past(REG_REQ.wdata[0], 2)
         && AUX_MAG_ENABLE == $past(REG_REQ.wdata[4], 2);
   endproperty
   a_ifset: assert property (p_ifset)
      else $error("interface settings outputs wrong");
   property p_selftest;
      REG_REQ.wr && REG_REQ.addr == 8'h6D |-> ##2
         SELFTEST_ENABLE == $past(REG_REQ.wdata[0], 2)
         && SELFTEST_POSITIVE == $past(REG_REQ.wdata[2], 2)
         && SELFTEST_HIGH_AMP == $past(REG_REQ.wdata[3], 2);
   endproperty
   a_selftest: assert property (p_selftest)
      else $error("self-test outputs wrong");
   property p_spisel;
      REG_REQ.wr && REG_REQ.addr == 8'h70 |-> ##2
         SPI_SELECT == $past(REG_REQ.wdata[0], 2);
   endproperty
   a_spisel: assert property (p_spisel)
      else $error("spi select wrong");
   property p_ro_read;
      REG_REQ.rd && REG_REQ.addr == 8'h5F |=> (REG_RDATA & 8'hF9) == 8'h00;
   endproperty
   a_ro_read: assert property (p_ro_read)
      else $error("fault register reserved bits set");
   property p_release;
      $rose(SDA_RELEASE) |=> !SDA_RELEASE;
   endproperty
   a_release: assert property (p_release)
      else $error("release not a single pulse");
   property p_acc_cause;
      ACC_OUT_VALID |-> $past(ACC_IN_VALID);
   endproperty
   a_acc_cause: assert property (p_acc_cause)
      else $error("data valid without input");
endmodule

bind scfg_regs scfg_regs_checker i_chk (
   .REF_CLK(REF_CLK), .RST(RST), .REG_REQ(REG_REQ),
   .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
   .FEAT_WR_PULSE(FEAT_WR_PULSE), .ERR_LONG_PROC(ERR_LONG_PROC),
   .ERR_FATAL(ERR_FATAL), .PROC_HALT(PROC_HALT),
   .NVM_PROG_STB(NVM_PROG_STB), .THREE_WIRE_SELECT(THREE_WIRE_SELECT),
   .AUX_MAG_ENABLE(AUX_MAG_ENABLE), .SELFTEST_ENABLE(SELFTEST_ENABLE),
   .SELFTEST_POSITIVE(SELFTEST_POSITIVE),
   .SELFTEST_HIGH_AMP(SELFTEST_HIGH_AMP), .SPI_SELECT(SPI_SELECT),
   .SDA_RELEASE(SDA_RELEASE), .ACC_IN_VALID(ACC_IN_VALID),
   .ACC_OUT_VALID(ACC_OUT_VALID));

// ### bench/scfg_host_model.sv
// host processor model issuing register reads and writes
// assumes requests are taken on the rising edge of clk
`timescale 1ns/1ps
module scfg_host_model (
   input  wire logic              clk,
   output scfg_pkg::scfg_reg_req_t req,
   input  wire logic [7:0]        rdata,
   input  wire logic              rvalid
);
   import scfg_pkg::*;
   initial req = '0;

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk);
      #1;
      req = '0;
   endtask

   // answer is sampled in the cycle after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic ok);
      @(posedge clk);
      #1;
      req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk);
      #1;
      req = '0;
      ok = rvalid;
      d = rdata;
   endtask
endmodule

// ### bench/scfg_regs_tb.sv
// self-checking bench for the configuration and status register bank
// assumes short watchdog counts of 20 and 60 cycles
`timescale 1ns/1ps
module scfg_regs_tb;
   import scfg_pkg::*;
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   scfg_reg_req_t   req;
   logic [7:0]      rdata, feat_data;
   logic            rvalid, feat_wr, feat_rd, halt, prog_en, stb;
   logic            err_long = 1'b0, err_fatal = 1'b0, nvm_load = 1'b0;
   logic            i2c_mode = 1'b0, sda = 1'b1, sda_rel, acc_v = 1'b0;
   logic            tws, aux, st_en, st_pos, st_amp, spi, acc_ov;
   scfg_nvm_image_t prog_img, load_img = '0;
   scfg_acc_t       acc_in = '0, acc_out;
   int              n_errors = 0;
   int              n_checks = 0;

   always #5 clk = ~clk;

   scfg_regs #(.WDT_SHORT_CYC(20), .WDT_LONG_CYC(60)) i_dut (
      .REF_CLK(clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
      .REG_RVALID(rvalid), .FEAT_DATA(feat_data), .FEAT_WR_PULSE(feat_wr),
      .FEAT_RD_PULSE(feat_rd), .ERR_LONG_PROC(err_long),
      .ERR_FATAL(err_fatal), .PROC_HALT(halt), .NVM_PROG_ENABLE(prog_en),
      .NVM_PROG_STB(stb), .NVM_PROG_IMAGE(prog_img), .NVM_LOAD(nvm_load),
      .NVM_LOAD_IMAGE(load_img), .THREE_WIRE_SELECT(tws),
      .AUX_MAG_ENABLE(aux), .SELFTEST_ENABLE(st_en),
      .SELFTEST_POSITIVE(st_pos), .SELFTEST_HIGH_AMP(st_amp),
      .SPI_SELECT(spi), .I2C_MODE(i2c_mode), .SDA_IN(sda),
      .SDA_RELEASE(sda_rel), .ACC_IN_VALID(acc_v), .ACC_IN(acc_in),
      .ACC_OUT_VALID(acc_ov), .ACC_OUT(acc_out));

   scfg_host_model i_host (.clk(clk), .req(req), .rdata(rdata),
                           .rvalid(rvalid));

   task automatic chk(input string nm, input logic [47:0] e,
                      input logic [47:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      i_host.rd(a, d, ok);
      chk("read valid", 48'h1, 48'(ok));
      chk($sformatf("register %h", a), 48'(e), 48'(d));
   endtask

   task automatic pulse(ref logic s);
      @(posedge clk);
      #1 s = 1'b1;
      @(posedge clk);
      #1 s = 1'b0;
   endtask

   task automatic acc(input scfg_acc_t a);
      @(posedge clk);
      #1 acc_in = a;
      acc_v = 1'b1;
      @(posedge clk);
      #1 acc_v = 1'b0;
   endtask

   task automatic do_reset;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
   endtask

   logic [7:0] tbl_a[8] = '{8'h5E, 8'h5F, 8'h6A, 8'h6B, 8'h6D, 8'h70,
                            8'h60, 8'h7E};
   logic [7:0] tbl_m[8] = '{8'hFF, 8'h00, 8'h02, 8'h11, 8'h0D, 8'h0F,
                            8'h00, 8'h00};

   task automatic t_reset;
      for (int i = 0; i < 8; i++)
         rdc(tbl_a[i], 8'h00);
      for (int i = 0; i < 3; i++)
         rdc(8'h71 + 8'(i), 8'h00);
      rdc(8'h5E, 8'h00);
      chk("feature read pulse", 48'h1, 48'(feat_rd));
      chk("pins", 48'h0, 48'({tws, aux, st_en, st_pos, st_amp, spi}));
      $display("reset values done");
   endtask

   task automatic t_masks;
      for (int i = 0; i < 8; i++)
      begin
         i_host.wr(tbl_a[i], 8'hFF);
         rdc(tbl_a[i], tbl_m[i]);
      end
      chk("pins", 48'h7F, 48'({tws, aux, st_en, st_pos, st_amp, spi,
                                prog_en}));
      chk("feature data", 48'hFF, 48'(feat_data));
      i_host.wr(8'h6B, 8'h10);
      i_host.wr(8'h6D, 8'h04);
      i_host.wr(8'h70, 8'h0E);
      // control pins lag their register by one cycle
      @(posedge clk);
      #1;
      chk("pins", 48'h14, 48'({tws, aux, st_en, st_pos, st_amp,
                                spi}));
      for (int i = 0; i < 8; i++)
         i_host.wr(tbl_a[i], 8'h00);
      $display("masks done");
   endtask

   task automatic t_nvm;
      i_host.wr(8'h70, 8'h0B);
      i_host.wr(8'h71, 8'h05);
      i_host.wr(8'h72, 8'hFA);
      i_host.wr(8'h73, 8'h7F);
      i_host.wr(8'h7E, 8'hA0);
      chk("refused strobe", 48'h0, 48'(stb));
      i_host.wr(8'h6A, 8'h02);
      i_host.wr(8'h7E, 8'hA0);
      chk("strobe", 48'h1, 48'(stb));
      chk("image", 48'h0B05FA7F, 48'(prog_img));
      load_img = '{persist: 8'hF8, off_x: 8'h06, off_y: 8'hFA,
                   off_z: 8'h7F};
      pulse(nvm_load);
      rdc(8'h70, 8'h08);
      rdc(8'h71, 8'h06);
      rdc(8'h72, 8'hFA);
      $display("nvm done");
   endtask

   task automatic t_offset;
      acc('{x: 16'sh0100, y: 16'sh8002, z: 16'sh7FF0});
      chk("acc valid", 48'h1, 48'(acc_ov));
      chk("acc offset", 48'h010680007FFF, 48'(acc_out));
      i_host.wr(8'h70, 8'h00);
      acc('{x: 16'sh0100, y: 16'sh8002, z: 16'sh7FF0});
      chk("acc plain", 48'h010080027FF0, 48'(acc_out));
      $display("offset done");
   endtask

   task automatic t_wdt;
      logic [7:0] cfg[3] = '{8'h04, 8'h06, 8'h00};
      int         n[3] = '{20, 60, 200};
      int         k;
      i2c_mode = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         i_host.wr(8'h70, cfg[i]);
         sda = 1'b0;
         k = 0;
         while (sda_rel !== 1'b1 && k < 100)
         begin
            @(posedge clk);
            #1 k++;
         end
         if (i < 2)
            chk("release delay", 48'h1,
                48'(k >= n[i] && k <= n[i] + 8));
         else
            chk("disabled release", 48'd100, 48'(k));
         sda = 1'b1;
         repeat (4) @(posedge clk);
      end
      i2c_mode = 1'b0;
      $display("watchdog done");
   endtask

   task automatic t_fault;
      pulse(err_long);
      chk("halt", 48'h1, 48'(halt));
      rdc(8'h5F, 8'h02);
      acc('{x: 16'sh0001, y: 16'sh0002, z: 16'sh0003});
      chk("halted valid", 48'h0, 48'(acc_ov));
      pulse(err_fatal);
      rdc(8'h5F, 8'h06);
      i_host.wr(8'h5F, 8'h00);
      rdc(8'h5F, 8'h06);
      do_reset();
      rdc(8'h5F, 8'h00);
      $display("faults done");
   endtask

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #200000;
      n_errors++;
      stop_test();
   end

   initial
   begin
      do_reset();
      t_reset();
      t_masks();
      t_nvm();
      t_offset();
      t_wdt();
      t_fault();
      stop_test();
   end
endmodule
